/* logic/pci_pin_interface_control.sv */
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
// Operation
// - with several pending bits, ack of one drops interrupt one cycle then reasserts
// - a data phase completes only when initiator and target ready both assert
// - master asserts initiator ready with write data driven or read ready
// - strap sampled on every reset: low gives mode 0, high gives mode 1
// - in mode 1 the strap pin becomes boot rom chip enable output
// - parity is even over 32 address/data and 4 command lines
// - parity covers every line in address and data phases
// - master data parity error sets status bits, finishes burst, then halts
// - after halt, operation resumes only when host clears system error bit
// - parity error pin asserts on master read or slave write data error
// - bus request asserts whenever master transfers are needed
// - during reset all bus outputs float and open-drain outputs release
// - interrupt asserts on unmasked status bit; write one clears status
module pci_pin_interface_control
    import pci_pin_pkg::*;
#(
    parameter int MAX_BURST = 16
)
(
    input wire logic clock_in,
    input wire logic reset_in,
    // local register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [31:0] reg_rdata_out,
    // internal event sources
    input wire logic [INT_WIDTH-1:0] int_event_in,
    // bus pins
    input wire logic [31:0] ad_in,
    output logic [31:0] ad_out,
    output logic ad_oe_out,
    input wire logic [3:0] cbe_n_in,
    output logic [3:0] cbe_n_out,
    output logic cbe_oe_out,
    input wire logic par_in,
    output logic par_out,
    output logic par_oe_out,
    output logic frame_n_out,
    output logic frame_oe_out,
    output logic irdy_n_out,
    output logic irdy_oe_out,
    input wire logic trdy_n_in,
    input wire logic gnt_n_in,
    output logic req_n_out,
    output logic req_oe_out,
    output logic perr_n_out,
    output logic perr_oe_out,
    output logic int_n_out,
    output logic int_oe_out,
    input wire logic slave_write_phase_in,
    // strap / boot rom chip enable pin
    input wire logic mode_strap_in,
    output logic boot_rom_chip_enable_n_out,
    output logic boot_rom_chip_enable_oe_out,
    input wire logic boot_rom_access_in,
    output logic mode_out
);

    if (MAX_BURST < 1 || MAX_BURST > 16)
    begin : g_burst_check
        $error("MAX_BURST must be 1 to 16");
    end

    typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_ADDR, ST_DATA, ST_TURN, ST_HALT} mstate_e;

    function automatic logic even_par(input logic [31:0] a, input logic [3:0] c);
        even_par = ^{a, c};
    endfunction : even_par

    // pin synchronisers
    logic [1:0] trdy_sync_q, gnt_sync_q, strap_sync_q, swr_sync_q;
    logic trdy_n, gnt_n, strap_s, slave_wr_s;
    always_ff @(posedge clock_in)
    begin
        trdy_sync_q <= {trdy_sync_q[0], trdy_n_in};
        gnt_sync_q <= {gnt_sync_q[0], gnt_n_in};
        strap_sync_q <= {strap_sync_q[0], mode_strap_in};
        swr_sync_q <= {swr_sync_q[0], slave_write_phase_in};
    end
    assign trdy_n = trdy_sync_q[1];
    assign gnt_n = gnt_sync_q[1];
    assign strap_s = strap_sync_q[1];
    assign slave_wr_s = swr_sync_q[1];

    // sampled bus data and parity, one clock apart for checking
    logic [31:0] ad_s1_q, ad_s2_q;
    logic [3:0] cbe_s1_q, cbe_s2_q;
    logic par_s1_q, par_s2_q;
    always_ff @(posedge clock_in)
    begin
        ad_s1_q <= ad_in;
        ad_s2_q <= ad_s1_q;
        cbe_s1_q <= cbe_n_in;
        cbe_s2_q <= cbe_s1_q;
        par_s1_q <= par_in;
        par_s2_q <= par_s1_q;
    end

    // mode strap: caught after reset release, software reset re-arms it
    logic strap_pending_q, mode_q, soft_reset;
    always_ff @(posedge clock_in)
    begin
        if (reset_in || soft_reset)
        begin
            strap_pending_q <= 1'b1;
            mode_q <= 1'b0;
        end
        else if (strap_pending_q)
        begin
            strap_pending_q <= 1'b0;
            mode_q <= strap_s;
        end
    end
    assign mode_out = mode_q;

    // registers
    logic [INT_WIDTH-1:0] int_status_q, int_mask_q;
    logic [31:0] cfg_status_q, mctrl_q, mdata_q, maddr_q, mrdata_q;
    logic [3:0] beats_q;
    mstate_e state_q;
    logic data_par_err, int_clr_any;
    logic [INT_WIDTH-1:0] int_set, int_clr;

    assign soft_reset = reg_write_in && reg_addr_in == ADDR_MASTER_CTRL && reg_wdata_in[31];
    assign int_clr = (reg_write_in && reg_addr_in == ADDR_INT_STATUS) ?
        reg_wdata_in[INT_WIDTH-1:0] : '0;

    always_comb
    begin
        int_set = int_event_in;
        int_set[INT_BIT_SYS_ERR] = int_event_in[INT_BIT_SYS_ERR] || data_par_err;
        int_set[INT_BIT_XFER_DONE] = int_event_in[INT_BIT_XFER_DONE]
            || (state_q == ST_TURN);
    end

    // set wins over clear
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            int_status_q <= '0;
        end
        else
        begin
            int_status_q <= (int_status_q & ~int_clr) | int_set;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            int_mask_q <= INT_MASK_RESET[INT_WIDTH-1:0];
        end
        else if (reg_write_in && reg_addr_in == ADDR_INT_MASK)
        begin
            int_mask_q <= reg_wdata_in[INT_WIDTH-1:0];
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            cfg_status_q <= 32'h0000_0000;
        end
        else
        begin
            if (reg_write_in && reg_addr_in == ADDR_CFG_STATUS)
            begin
                cfg_status_q <= cfg_status_q & ~reg_wdata_in;
            end
            if (data_par_err)
            begin
                cfg_status_q[CFG_BIT_DATA_PAR_REPORT] <= 1'b1;
                cfg_status_q[CFG_BIT_DETECTED_PAR_ERR] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            mdata_q <= 32'h0000_0000;
            maddr_q <= 32'h0000_0000;
        end
        else if (reg_write_in && reg_addr_in == ADDR_MASTER_DATA)
        begin
            mdata_q <= reg_wdata_in;
        end
        else if (reg_write_in && reg_addr_in == ADDR_MASTER_ADDR)
        begin
            maddr_q <= reg_wdata_in;
        end
    end

    // interrupt line with one-cycle gap after a partial acknowledge
    logic int_pend, int_gap_q;
    assign int_pend = |(int_status_q & int_mask_q);
    assign int_clr_any = |(int_clr & int_status_q & int_mask_q);
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            int_gap_q <= 1'b0;
        end
        else
        begin
            int_gap_q <= int_clr_any;
        end
    end

    // master engine
    logic start_req, is_write, phase_done;
    assign start_req = reg_write_in && reg_addr_in == ADDR_MASTER_CTRL
        && reg_wdata_in[MCTRL_BIT_START];
    assign is_write = mctrl_q[MCTRL_BIT_WRITE];
    assign phase_done = state_q == ST_DATA && !trdy_n;

    logic halt_q, perr_seen_q;
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            mctrl_q <= 32'h0000_0000;
        end
        else if (start_req && state_q == ST_IDLE)
        begin
            mctrl_q <= reg_wdata_in;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            state_q <= ST_IDLE;
            beats_q <= 4'h0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (start_req && !halt_q)
                    begin
                        state_q <= ST_REQ;
                    end
                end
                ST_REQ:
                begin
                    if (!gnt_n)
                    begin
                        state_q <= ST_ADDR;
                    end
                end
                ST_ADDR:
                begin
                    state_q <= ST_DATA;
                    beats_q <= (32'(mctrl_q[MCTRL_LEN_LSB +: MCTRL_LEN_W]) < MAX_BURST) ?
                        mctrl_q[MCTRL_LEN_LSB +: MCTRL_LEN_W] : 4'(MAX_BURST - 1);
                end
                ST_DATA:
                begin
                    if (phase_done)
                    begin
                        if (beats_q == 4'h0)
                        begin
                            state_q <= ST_TURN; // burst finishes first
                        end
                        else
                        begin
                            beats_q <= beats_q - 4'h1;
                        end
                    end
                end
                ST_TURN:
                begin
                    // an error on the last beat is flagged in this very cycle
                    state_q <= (halt_q || perr_seen_q || data_par_err) ? ST_HALT : ST_IDLE;
                end
                ST_HALT:
                begin
                    if (!int_status_q[INT_BIT_SYS_ERR])
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // read data capture
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            mrdata_q <= 32'h0000_0000;
        end
        else if (phase_done && !is_write)
        begin
            mrdata_q <= ad_s1_q;
        end
    end

    // data parity check: data sampled at phase end, parity one clock later
    logic chk_q, chk_master_q;
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            chk_q <= 1'b0;
            chk_master_q <= 1'b0;
        end
        else
        begin
            chk_q <= (phase_done && !is_write) || slave_wr_s;
            chk_master_q <= phase_done && !is_write;
        end
    end
    logic par_bad;
    assign par_bad = chk_q && (even_par(ad_s2_q, cbe_s2_q) != par_s1_q);
    assign data_par_err = par_bad && chk_master_q;

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            halt_q <= 1'b0;
            perr_seen_q <= 1'b0;
        end
        else
        begin
            if (data_par_err)
            begin
                perr_seen_q <= 1'b1;
                halt_q <= 1'b1;
            end
            else if (state_q == ST_HALT && !int_status_q[INT_BIT_SYS_ERR])
            begin
                perr_seen_q <= 1'b0;
                halt_q <= 1'b0;
            end
        end
    end

    // bus drive
    logic drive_q, par_oe_q, par_q, perr_q;
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            ad_out <= 32'h0000_0000;
            cbe_n_out <= 4'hF;
            drive_q <= 1'b0;
        end
        else
        begin
            // drive from the address cycle, and through write data until the last beat ends
            drive_q <= (state_q == ST_REQ && !gnt_n) || (is_write && (state_q == ST_ADDR
                || (state_q == ST_DATA && !(phase_done && beats_q == 4'h0))));
            if (state_q == ST_REQ && !gnt_n)
            begin
                ad_out <= maddr_q;
                cbe_n_out <= is_write ? CMD_MEM_WRITE : CMD_MEM_READ;
            end
            else
            begin
                ad_out <= mdata_q; // write data valid with irdy
                cbe_n_out <= 4'h0;
            end
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            par_q <= 1'b0;
            par_oe_q <= 1'b0;
            perr_q <= 1'b0;
        end
        else
        begin
            par_q <= even_par(ad_out, cbe_n_out);
            par_oe_q <= drive_q;
            perr_q <= par_bad;
        end
    end

    always_comb
    begin
        ad_oe_out = drive_q && !reset_in;
        cbe_oe_out = (state_q == ST_ADDR || state_q == ST_DATA) && !reset_in;
        par_out = par_q;
        par_oe_out = par_oe_q && !reset_in;
        frame_oe_out = cbe_oe_out;
        frame_n_out = !(state_q == ST_ADDR || (state_q == ST_DATA && beats_q != 4'h0));
        irdy_oe_out = cbe_oe_out;
        irdy_n_out = !(state_q == ST_DATA);
        req_n_out = !(state_q == ST_REQ || state_q == ST_ADDR);
        req_oe_out = !reset_in;
        perr_n_out = 1'b0;
        perr_oe_out = perr_q && !reset_in;
        int_n_out = 1'b0;
        int_oe_out = int_pend && !int_gap_q && !reset_in;
        boot_rom_chip_enable_n_out = !boot_rom_access_in;
        boot_rom_chip_enable_oe_out = mode_q && !strap_pending_q && !reset_in;
    end

    // register read port
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            reg_rdata_out <= 32'h0000_0000;
        end
        else if (reg_read_in)
        begin
            case (reg_addr_in)
                ADDR_INT_STATUS: reg_rdata_out <= 32'(int_status_q);
                ADDR_INT_MASK: reg_rdata_out <= 32'(int_mask_q);
                ADDR_CFG_STATUS: reg_rdata_out <= cfg_status_q;
                ADDR_MASTER_CTRL: reg_rdata_out <= mctrl_q;
                ADDR_MASTER_DATA: reg_rdata_out <= mdata_q;
                ADDR_MASTER_ADDR: reg_rdata_out <= maddr_q;
                ADDR_MASTER_STAT: reg_rdata_out <= {27'h0, halt_q, mode_q, 3'(state_q)};
                ADDR_MASTER_RDATA: reg_rdata_out <= mrdata_q;
                default: reg_rdata_out <= 32'h0000_0000;
            endcase
        end
        else
        begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end

endmodule : pci_pin_interface_control

/* logic/pci_pin_pkg.sv */
package pci_pin_pkg;
    // register offsets on the local register port
    localparam logic [3:0] ADDR_INT_STATUS = 4'h0;
    localparam logic [3:0] ADDR_INT_MASK = 4'h1;
    localparam logic [3:0] ADDR_CFG_STATUS = 4'h2;
    localparam logic [3:0] ADDR_MASTER_CTRL = 4'h3;
    localparam logic [3:0] ADDR_MASTER_DATA = 4'h4;
    localparam logic [3:0] ADDR_MASTER_ADDR = 4'h5;
    localparam logic [3:0] ADDR_MASTER_STAT = 4'h6;
    localparam logic [3:0] ADDR_MASTER_RDATA = 4'h7;
    // interrupt status bit positions
    localparam int INT_BIT_SYS_ERR = 13;
    localparam int INT_BIT_XFER_DONE = 0;
    localparam int INT_WIDTH = 17;
    // configuration status bit positions
    localparam int CFG_BIT_DATA_PAR_REPORT = 24;
    localparam int CFG_BIT_DETECTED_PAR_ERR = 31;
    // master control fields
    localparam int MCTRL_BIT_START = 0;
    localparam int MCTRL_BIT_WRITE = 1;
    localparam int MCTRL_LEN_LSB = 4;
    localparam int MCTRL_LEN_W = 4;
    localparam int MCTRL_CMD_LSB = 8;
    // reset value and bus command codes
    localparam logic [31:0] INT_MASK_RESET = 32'h0000_0000;
    localparam logic [3:0] CMD_MEM_READ = 4'h6;
    localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
    // cycles that the interrupt line is released between pending events
    localparam int INT_GAP_CYCLES = 1;
endpackage : pci_pin_pkg

/* bench/pci_pin_asserts.sv */
`timescale 1ns/1ps
module pci_pin_asserts
    import pci_pin_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic [INT_WIDTH-1:0] int_event_in,
    input wire logic [31:0] ad_out,
    input wire logic ad_oe_out,
    input wire logic [3:0] cbe_n_out,
    input wire logic cbe_oe_out,
    input wire logic par_out,
    input wire logic par_oe_out,
    input wire logic frame_n_out,
    input wire logic frame_oe_out,
    input wire logic irdy_n_out,
    input wire logic irdy_oe_out,
    input wire logic trdy_n_in,
    input wire logic req_n_out,
    input wire logic req_oe_out,
    input wire logic perr_oe_out,
    input wire logic int_oe_out,
    input wire logic mode_strap_in,
    input wire logic mode_out,
    input wire logic boot_rom_chip_enable_n_out,
    input wire logic boot_rom_chip_enable_oe_out,
    input wire logic boot_rom_access_in
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (reset_in);
    wire irdy_on = irdy_oe_out && !irdy_n_out;
    wire clr_int = reg_write_in && reg_addr_in == ADDR_INT_STATUS && reg_wdata_in != 32'h0;
    a_reset_floats: assert property (disable iff (1'b0) reset_in |-> !(ad_oe_out
        || cbe_oe_out || par_oe_out || frame_oe_out || irdy_oe_out || req_oe_out
        || perr_oe_out || int_oe_out)) else $error("bus driven in reset");
    a_parity_even: assert property (par_oe_out |->
        par_out == ^{$past(ad_out), $past(cbe_n_out)}) else $error("bad parity");
    a_irdy_waits: assert property ((irdy_on && trdy_n_in) [*3] |=> irdy_on)
        else $error("phase ended without target ready");
    a_write_held: assert property ((irdy_on && ad_oe_out && trdy_n_in) [*3] |=>
        ad_oe_out && $stable(ad_out)) else $error("write data not held");
    a_req_first: assert property ($fell(frame_n_out) && frame_oe_out |->
        $past(req_oe_out && !req_n_out, 2)) else $error("frame without request");
    a_int_gap: assert property (clr_int && int_oe_out && int_event_in == 0 |=>
        !int_oe_out) else $error("no interrupt gap");
    a_perr_pulse: assert property ($rose(perr_oe_out) |=> !perr_oe_out)
        else $error("parity error pulse too long");
    a_rom_enable: assert property (boot_rom_chip_enable_oe_out |-> mode_out
        && boot_rom_chip_enable_n_out == !boot_rom_access_in) else $error("bad rom enable");
    a_mode_sample: assert property ($fell(reset_in) |-> ##3 mode_out == mode_strap_in)
        else $error("mode not sampled");
    a_addr_driven: assert property ($fell(frame_n_out) && frame_oe_out |-> ad_oe_out
        && (cbe_n_out == CMD_MEM_WRITE || cbe_n_out == CMD_MEM_READ))
        else $error("address phase not driven");
    c_frame: cover property ($fell(frame_n_out) && frame_oe_out);
    c_perr: cover property ($rose(perr_oe_out));
    c_gap: cover property (clr_int && int_oe_out ##1 !int_oe_out ##1 int_oe_out);
    c_rom: cover property (boot_rom_chip_enable_oe_out);
endmodule : pci_pin_asserts

bind pci_pin_interface_control pci_pin_asserts pci_pin_asserts_i (.*);

/* bench/pci_target_model.sv */
`timescale 1ns/1ps
module pci_target_model
#(
    parameter logic [31:0] READ_WORD = 32'hA5C3_0F96
)
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic req_n_in,
    input wire logic irdy_n_in,
    input wire logic irdy_oe_in,
    input wire logic [31:0] ad_in,
    input wire logic ad_oe_in,
    input wire logic [3:0] cbe_n_in,
    input wire logic [3:0] wait_in,
    input wire logic bad_par_in,
    output logic gnt_n_out,
    output logic trdy_n_out,
    output logic [31:0] ad_out,
    output logic par_out,
    output logic [7:0] beats_out,
    output logic [31:0] wdata_out
);
    logic [3:0] cnt_q;
    wire irdy = irdy_oe_in && !irdy_n_in;
    // arbiter grants whenever asked
    always_ff @(posedge clock_in) gnt_n_out <= reset_in | req_n_in;
    // target waits wait_in cycles, then readies for one cycle per beat
    always_ff @(posedge clock_in)
    begin
        if (reset_in || !irdy || !trdy_n_out)
        begin
            cnt_q <= 4'h0;
            trdy_n_out <= 1'b1;
        end
        else if (cnt_q == wait_in)
            trdy_n_out <= 1'b0;
        else
            cnt_q <= cnt_q + 4'h1;
    end
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            beats_out <= 8'h00;
        else if (irdy && !trdy_n_out)
        begin
            beats_out <= beats_out + 8'h01;
            wdata_out <= ad_in;
        end
    end
    // read data only while the master waits; otherwise a toggling pattern
    always_ff @(posedge clock_in)
    begin
        ad_out <= reset_in ? 32'h0 : ((irdy && !ad_oe_in) ? READ_WORD : ~ad_out);
        par_out <= ^{ad_in, cbe_n_in} ^ bad_par_in;
    end
endmodule : pci_target_model

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import pci_pin_pkg::*;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    logic slave_write_phase_in = 1'b0;
    logic mode_strap_in = 1'b0;
    logic boot_rom_access_in = 1'b0;
    logic bad_par = 1'b0;
    logic perr_seen = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [3:0] wait_n = 4'h3;
    logic [31:0] reg_wdata_in = 32'h0;
    logic [INT_WIDTH-1:0] int_event_in = {INT_WIDTH{1'b0}};
    logic [7:0] b0;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    wire logic [31:0] reg_rdata_out, ad_in, ad_out, m_ad, wseen;
    wire logic [3:0] cbe_n_in, cbe_n_out;
    wire logic [7:0] beats;
    wire logic ad_oe_out, cbe_oe_out, par_in, par_out, par_oe_out, frame_n_out, frame_oe_out;
    wire logic irdy_n_out, irdy_oe_out, trdy_n_in, gnt_n_in, req_n_out, req_oe_out;
    wire logic perr_n_out, perr_oe_out, int_n_out, int_oe_out, mode_out, m_par, req_wire;
    wire logic boot_rom_chip_enable_n_out, boot_rom_chip_enable_oe_out;
    assign ad_in = ad_oe_out ? ad_out : m_ad;
    assign cbe_n_in = cbe_oe_out ? cbe_n_out : ~cbe_n_out;
    assign par_in = par_oe_out ? par_out : m_par;
    assign req_wire = req_oe_out ? req_n_out : 1'b1;
    pci_pin_interface_control pci_pin_interface_control_i (.*);
    pci_target_model pci_target_model_i (.clock_in(clock_in), .reset_in(reset_in),
        .req_n_in(req_wire), .irdy_n_in(irdy_n_out), .irdy_oe_in(irdy_oe_out), .ad_in(ad_in),
        .ad_oe_in(ad_oe_out), .cbe_n_in(cbe_n_in), .wait_in(wait_n), .bad_par_in(bad_par),
        .gnt_n_out(gnt_n_in), .trdy_n_out(trdy_n_in), .ad_out(m_ad), .par_out(m_par),
        .beats_out(beats), .wdata_out(wseen));
    initial forever #12.5 clock_in = ~clock_in;
    always @(posedge clock_in)
    begin
        cycles <= cycles + 1;
        if (perr_oe_out === 1'b1)
            perr_seen <= 1'b1;
        if (cycles == 20000)
        begin
            miscompares++;
            stop_test();
        end
    end
    task stop_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : tick
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge clock_in);
        reg_write_in <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge clock_in);
        reg_read_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask : rd
    task rchk(input string n, input logic [3:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(n, e, d);
    endtask : rchk
    task burst(input logic w, input logic [3:0] len, input logic [7:0] n);
        logic [31:0] d;
        d = 32'h0;
        b0 = beats;
        perr_seen = 1'b0;
        wr(ADDR_MASTER_CTRL, {20'h0, w ? CMD_MEM_WRITE : CMD_MEM_READ, len, 2'h0, w, 1'h1});
        for (int i = 0; i < 100 && d[INT_BIT_XFER_DONE] !== 1'b1; i++)
            rd(ADDR_INT_STATUS, d);
        wr(ADDR_INT_STATUS, 32'h1);
        chk("beats", {24'h0, n}, {24'h0, beats - b0});
    endtask : burst
    task t_int;
        wr(ADDR_INT_MASK, 32'h28);
        rchk("mask", ADDR_INT_MASK, 32'h28);
        @(posedge clock_in);
        int_event_in <= 17'h0228;
        @(posedge clock_in);
        int_event_in <= 17'h0;
        tick(1);
        chk("int on", 32'h1, {31'h0, int_oe_out});
        wr(ADDR_INT_STATUS, 32'h8);
        #1 chk("int gap", 32'h0, {31'h0, int_oe_out});
        tick(1);
        chk("int back", 32'h1, {31'h0, int_oe_out});
        wr(ADDR_INT_STATUS, 32'h20);
        tick(2);
        chk("int off", 32'h0, {31'h0, int_oe_out});
        rchk("masked bit", ADDR_INT_STATUS, 32'h200);
        wr(ADDR_INT_STATUS, 32'h200);
    endtask : t_int
    task t_bursts;
        wr(ADDR_MASTER_DATA, 32'h5A0F_C3E1);
        wr(ADDR_MASTER_ADDR, 32'h0000_1000);
        burst(1'b1, 4'h2, 8'h03);
        chk("write data", 32'h5A0F_C3E1, wseen);
        wait_n = 4'h6;
        burst(1'b0, 4'h0, 8'h01);
        rchk("read data", ADDR_MASTER_RDATA, 32'hA5C3_0F96);
        chk("no perr", 32'h0, {31'h0, perr_seen});
    endtask : t_bursts
    task t_parerr;
        logic [31:0] d;
        wait_n = 4'h3;
        bad_par = 1'b1;
        burst(1'b0, 4'h1, 8'h02);
        bad_par = 1'b0;
        chk("perr", 32'h1, {31'h0, perr_seen});
        rchk("sys err", ADDR_INT_STATUS, 32'h2000);
        rchk("cfg bits", ADDR_CFG_STATUS, 32'h8100_0000);
        rd(ADDR_MASTER_STAT, d);
        chk("halted", 32'h10, d & 32'h18);
        wr(ADDR_INT_STATUS, 32'h2000);
        wr(ADDR_CFG_STATUS, 32'h8100_0000);
        rd(ADDR_MASTER_STAT, d);
        chk("resumed", 32'h0, d & 32'h10);
        burst(1'b1, 4'h0, 8'h01);
        bad_par = 1'b1;
        burst(1'b0, 4'h0, 8'h01);
        bad_par = 1'b0;
        rd(ADDR_MASTER_STAT, d);
        chk("halted last", 32'h10, d & 32'h18);
        wr(ADDR_INT_STATUS, 32'h2000);
        wr(ADDR_CFG_STATUS, 32'h8100_0000);
    endtask : t_parerr
    task t_slave;
        perr_seen = 1'b0;
        @(posedge clock_in);
        bad_par <= 1'b1;
        slave_write_phase_in <= 1'b1;
        @(posedge clock_in);
        slave_write_phase_in <= 1'b0;
        tick(6);
        bad_par <= 1'b0;
        chk("slave perr", 32'h1, {31'h0, perr_seen});
        rchk("no halt", ADDR_INT_STATUS, 32'h0);
        rchk("no cfg", ADDR_CFG_STATUS, 32'h0);
    endtask : t_slave
    task t_mode;
        mode_strap_in <= 1'b1;
        tick(4);
        wr(ADDR_MASTER_CTRL, 32'h8000_0000);
        tick(5);
        chk("mode 1", 32'h1, {31'h0, mode_out});
        chk("rom oe", 32'h1, {31'h0, boot_rom_chip_enable_oe_out});
        boot_rom_access_in <= 1'b1;
        tick(1);
        chk("rom ce", 32'h0, {31'h0, boot_rom_chip_enable_n_out});
        mode_strap_in <= 1'b0;
        reset_in <= 1'b1;
        tick(12);
        reset_in <= 1'b0;
        tick(5);
        chk("mode 0", 32'h0, {31'h0, mode_out});
        chk("rom off", 32'h0, {31'h0, boot_rom_chip_enable_oe_out});
    endtask : t_mode
    initial
    begin
        tick(12);
        chk("floating", 32'h0, {24'h0, ad_oe_out, cbe_oe_out, par_oe_out, frame_oe_out,
            irdy_oe_out, req_oe_out, perr_oe_out, int_oe_out});
        reset_in <= 1'b0;
        tick(5);
        chk("mode 0", 32'h0, {31'h0, mode_out});
        rchk("mask reset", ADDR_INT_MASK, INT_MASK_RESET);
        rchk("unmapped", 4'hF, 32'h0);
        t_int();
        t_bursts();
        t_parerr();
        t_slave();
        t_mode();
        stop_test();
    end
endmodule : testbench
